// file: common/tmi_bus_if.sv
// Two-wire bus joining the host end and the target end.
// Both lines are open drain: a line is low while any party enables its driver.
`timescale 1ns/1ps
`default_nettype none
interface tmi_bus_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_scl_o;
   logic dev_scl_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Wired AND with pull-ups: a driver only ever pulls to its output level, which is low.
   assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                 output host_sda_oe, input scl, input sda);
   modport dev  (output dev_scl_o, output dev_scl_oe, output dev_sda_o,
                 output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// file: common/tmi_cfg.svh
// Constants shared by both ends of the touch module two-wire link.
// Assumes nothing beyond being included by its bare name.
`ifndef TMI_CFG_SVH
`define TMI_CFG_SVH

// Target addresses, seven bits each.
`define TMI_ADDR_TOUCH_LO 7'h4a
`define TMI_ADDR_TOUCH_HI 7'h4b
`define TMI_ADDR_NAV      7'h1b

// Frame layout: bits before the acknowledge cycle.
`define TMI_ADDR_BITS     4'h8
`define TMI_DATA_BITS     4'h8
`define TMI_LAST_BIT      4'h8

// Host timing: fastest serial clock and the host's own clock, in kHz.
`define TMI_SCL_MAX_KHZ   400
`define TMI_CLK_KHZ       25000
// Quarter of a serial clock period in host cycles, rounded up so the bus never runs fast.
`define TMI_QUARTER_CYC   ((`TMI_CLK_KHZ + 4 * `TMI_SCL_MAX_KHZ - 1) / (4 * `TMI_SCL_MAX_KHZ))

`endif

// file: common/tmi_pkg.sv
// Types shared by both ends of the touch module two-wire link.
// Assumes nothing from tmi_cfg.svh; it only needs compiling before its users.
package tmi_pkg;

   // Target side bit engine states.
   typedef enum logic [2:0] {
      TS_IDLE = 3'h0,
      TS_ADDR = 3'h1,
      TS_AACK = 3'h2,
      TS_RX   = 3'h3,
      TS_RACK = 3'h4,
      TS_TXW  = 3'h5,
      TS_TX   = 3'h6,
      TS_TACK = 3'h7
   } tmi_tst_t;

   // Host side states.
   typedef enum logic [1:0] {
      HS_IDLE  = 2'h0,
      HS_START = 2'h1,
      HS_STOP  = 2'h2,
      HS_BYTE  = 2'h3
   } tmi_hst_t;

   // Host commands.
   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_STOP  = 2'h1,
      CMD_WRITE = 2'h2,
      CMD_READ  = 2'h3
   } tmi_cmd_t;

endpackage

// file: design/tmi_host.sv
// Host end: turns byte-level commands into START, STOP and byte frames.
// Assumes a 25 MHz clock; the serial clock is divided down from it.
`timescale 1ns/1ps
`default_nettype none
`include "tmi_cfg.svh"
module tmi_host #(
   parameter int QUARTER = `TMI_QUARTER_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   tmi_bus_if.host          bus,
   input  wire logic        cmd_valid,
   input  wire logic [1:0]  cmd,
   input  wire logic [7:0]  cmd_data,
   input  wire logic        cmd_ack,
   output var  logic        cmd_ready,
   output var  logic        rsp_valid,
   output var  logic [7:0]  rsp_data,
   output var  logic        rsp_nack
);
   typedef struct packed {
      logic                 scl_m;
      logic                 scl_s;
      logic                 sda_m;
      logic                 sda_s;
      tmi_pkg::tmi_hst_t    st;
      logic [1:0]           ph;
      logic [7:0]           tick;
      logic [3:0]           bit_n;
      logic [8:0]           sh;
      logic [8:0]           rsh;
      logic                 scl_oe;
      logic                 sda_oe;
      logic                 rdy;
      logic                 rsp_valid;
      logic [7:0]           rsp_data;
      logic                 rsp_nack;
   } tmi_host_st_t;

   tmi_host_st_t h_ff;
   tmi_host_st_t nxt_h;
   logic         adv;

   // Each bit is four quarters; the line changes only at the end of a quarter.
   always_comb begin
      nxt_h = h_ff;
      nxt_h.scl_m = bus.scl;
      nxt_h.scl_s = h_ff.scl_m;
      nxt_h.sda_m = bus.sda;
      nxt_h.sda_s = h_ff.sda_m;
      nxt_h.rsp_valid = 1'b0;
      adv = (h_ff.tick == 8'(QUARTER - 1));
      nxt_h.tick = adv ? 8'h00 : h_ff.tick + 8'h01;
      // Quarter one waits for the line really to be high, so a stretching target is honoured.
      if (h_ff.ph == 2'h1 && !h_ff.scl_s) begin
         nxt_h.tick = 8'h00;
         adv = 1'b0;
      end
      case (h_ff.st)
         tmi_pkg::HS_IDLE: begin
            nxt_h.rdy = 1'b1;
            nxt_h.tick = 8'h00;
            nxt_h.ph = 2'h0;
            if (cmd_valid && h_ff.rdy) begin
               nxt_h.rdy = 1'b0;
               nxt_h.bit_n = 4'h0;
               case (tmi_pkg::tmi_cmd_t'(cmd))
                  tmi_pkg::CMD_START: begin
                     nxt_h.st = tmi_pkg::HS_START;
                     nxt_h.sda_oe = 1'b0;
                  end
                  tmi_pkg::CMD_STOP: begin
                     nxt_h.st = tmi_pkg::HS_STOP;
                     nxt_h.sda_oe = 1'b1;
                  end
                  tmi_pkg::CMD_WRITE: begin
                     nxt_h.st = tmi_pkg::HS_BYTE;
                     nxt_h.sh = {cmd_data, 1'b1};
                     nxt_h.sda_oe = ~cmd_data[7];
                  end
                  default: begin
                     nxt_h.st = tmi_pkg::HS_BYTE;
                     nxt_h.sh = {8'hff, ~cmd_ack};
                     nxt_h.sda_oe = 1'b0;
                  end
               endcase
            end
         end
         // START and STOP move the data line while the clock is high.
         tmi_pkg::HS_START,
         tmi_pkg::HS_STOP: begin
            if (adv) begin
               nxt_h.ph = h_ff.ph + 2'h1;
               case (h_ff.ph)
                  2'h0: nxt_h.scl_oe = 1'b0;
                  2'h1: nxt_h.sda_oe = (h_ff.st == tmi_pkg::HS_START);
                  2'h2: nxt_h.scl_oe = (h_ff.st == tmi_pkg::HS_START);
                  default: nxt_h.st = tmi_pkg::HS_IDLE;
               endcase
            end
         end
         default: begin
            if (adv) begin
               nxt_h.ph = h_ff.ph + 2'h1;
               case (h_ff.ph)
                  2'h0: nxt_h.scl_oe = 1'b0;
                  2'h1: nxt_h.rsh = {h_ff.rsh[7:0], h_ff.sda_s};
                  2'h2: nxt_h.scl_oe = 1'b1;
                  default: begin
                     nxt_h.bit_n = h_ff.bit_n + 4'h1;
                     if (h_ff.bit_n == `TMI_LAST_BIT) begin
                        nxt_h.st = tmi_pkg::HS_IDLE;
                        nxt_h.sda_oe = 1'b0;
                        nxt_h.rsp_valid = 1'b1;
                        nxt_h.rsp_data = h_ff.rsh[8:1];
                        nxt_h.rsp_nack = h_ff.rsh[0];
                     end else begin
                        nxt_h.sh = {h_ff.sh[7:0], 1'b1};
                        nxt_h.sda_oe = ~h_ff.sh[7];
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         h_ff <= '{st: tmi_pkg::HS_IDLE, sh: 9'h1ff, scl_m: 1'b1, scl_s: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, default: '0};
      end else begin
         h_ff <= nxt_h;
      end
   end

   // Open drain: the output level is always low, only the enables move.
   assign bus.host_scl_o  = 1'b0;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_scl_oe = h_ff.scl_oe;
   assign bus.host_sda_oe = h_ff.sda_oe;
   assign cmd_ready = h_ff.rdy;
   assign rsp_valid = h_ff.rsp_valid;
   assign rsp_data  = h_ff.rsp_data;
   assign rsp_nack  = h_ff.rsp_nack;
endmodule
`default_nettype wire

// file: design/tmi_target.sv
// Target end of the module: the touch target and the key target on one bus.
// Assumes the link logic runs on link_clk, fast enough to oversample the
// serial lines, and that the user side runs on clock.
`timescale 1ns/1ps
`default_nettype none
`include "tmi_cfg.svh"
// Function
// - Touch target answers 0x4a or 0x4b by strap.
// - Key target answers fixed address 0x1b.
// - Host keeps serial clock at most 400 kHz.
// - Lines are open drain, wired AND.
// - One clock pulse per bit; data steady high.
// - Host frames with START and STOP.
// - Busy from START until STOP.
// - Address frame: seven bits, direction, acknowledge.
// - Direction one reads, zero writes.
// - Own address acknowledged in ninth cycle.
// - Most significant bit goes first.
// - Data frame: eight bits plus acknowledge.
// - Received bytes acknowledged; high means not-acknowledge.
// - Host alone makes clock and framing.
// - START, address, data frames, STOP in order.
// - Target may stretch clock between frames.
// - Behaviour follows two-wire bus revision 2.1.
module tmi_target (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        link_clk,
   tmi_bus_if.dev           bus,
   input  wire logic        addr_strap,
   input  wire logic [7:0]  tx_byte_touch,
   input  wire logic [7:0]  tx_byte_nav,
   output var  logic        tx_taken,
   output var  logic        tx_target,
   output var  logic        rx_valid,
   output var  logic [7:0]  rx_data,
   output var  logic        rx_target,
   output var  logic        rx_first,
   output var  logic        bus_busy
);
   // Link side state; tgt is 1 for the key target.
   typedef struct packed {
      logic                 scl_m;
      logic                 scl_s;
      logic                 scl_q;
      logic                 sda_m;
      logic                 sda_s;
      logic                 sda_q;
      logic                 strap_m;
      logic                 strap_s;
      logic                 addr_hi;
      logic                 ack_m;
      logic                 ack_s;
      tmi_pkg::tmi_tst_t    st;
      logic [3:0]           cnt;
      logic [7:0]           sh;
      logic                 rd;
      logic                 tgt;
      logic                 busy;
      logic                 first;
      logic                 hack;
      logic                 scl_oe;
      logic                 sda_oe;
      logic                 rx_tgl;
      logic [7:0]           rx_hold;
      logic                 rx_tgt;
      logic                 rx_first;
      logic                 tx_req;
   } tmi_link_st_t;

   // User side state.
   typedef struct packed {
      logic                 rx_m;
      logic                 rx_s;
      logic                 rx_q;
      logic                 req_m;
      logic                 req_s;
      logic                 busy_m;
      logic                 busy_s;
      logic                 ack_tgl;
      logic [7:0]           tx_hold;
      logic                 tx_taken;
      logic                 tx_target;
      logic                 rx_valid;
      logic [7:0]           rx_data;
      logic                 rx_target;
      logic                 rx_first;
   } tmi_user_st_t;

   tmi_link_st_t l_ff;
   tmi_link_st_t nxt_l;
   tmi_user_st_t u_ff;
   tmi_user_st_t nxt_u;
   logic         rise;
   logic         fall;
   logic         start;
   logic         stop;
   logic         hit_touch;
   logic         hit_nav;

   // Link side: conditions are judged on the synchronised lines only.
   always_comb begin
      nxt_l = l_ff;
      nxt_l.scl_m = bus.scl;
      nxt_l.scl_s = l_ff.scl_m;
      nxt_l.scl_q = l_ff.scl_s;
      nxt_l.sda_m = bus.sda;
      nxt_l.sda_s = l_ff.sda_m;
      nxt_l.sda_q = l_ff.sda_s;
      nxt_l.strap_m = addr_strap;
      nxt_l.strap_s = l_ff.strap_m;
      nxt_l.ack_m = u_ff.ack_tgl;
      nxt_l.ack_s = l_ff.ack_m;
      rise  = l_ff.scl_s & ~l_ff.scl_q;
      fall  = ~l_ff.scl_s & l_ff.scl_q;
      start = l_ff.scl_s & l_ff.scl_q & l_ff.sda_q & ~l_ff.sda_s;
      stop  = l_ff.scl_s & l_ff.scl_q & ~l_ff.sda_q & l_ff.sda_s;
      hit_touch = (l_ff.sh[7:1] == (l_ff.addr_hi ? `TMI_ADDR_TOUCH_HI
                                                  : `TMI_ADDR_TOUCH_LO));
      hit_nav   = (l_ff.sh[7:1] == `TMI_ADDR_NAV);
      // The strap is followed only while idle, so a live change never splits a frame.
      if (!l_ff.busy) begin
         nxt_l.addr_hi = l_ff.strap_s;
      end
      if (start) begin
         // A START in mid-transaction drops the byte and waits for an address.
         nxt_l.st = tmi_pkg::TS_ADDR;
         nxt_l.busy = 1'b1;
         nxt_l.cnt = 4'h0;
         nxt_l.sda_oe = 1'b0;
         nxt_l.scl_oe = 1'b0;
      end else if (stop) begin
         nxt_l.st = tmi_pkg::TS_IDLE;
         nxt_l.busy = 1'b0;
         nxt_l.sda_oe = 1'b0;
         nxt_l.scl_oe = 1'b0;
      end else begin
         case (l_ff.st)
            tmi_pkg::TS_ADDR: begin
               if (rise) begin
                  nxt_l.sh = {l_ff.sh[6:0], l_ff.sda_s};
                  nxt_l.cnt = l_ff.cnt + 4'h1;
               end
               if (fall && l_ff.cnt == `TMI_ADDR_BITS) begin
                  if (hit_touch || hit_nav) begin
                     nxt_l.sda_oe = 1'b1;
                     nxt_l.rd = l_ff.sh[0];
                     nxt_l.tgt = hit_nav;
                     nxt_l.st = tmi_pkg::TS_AACK;
                  end else begin
                     nxt_l.st = tmi_pkg::TS_IDLE;
                  end
               end
            end
            tmi_pkg::TS_AACK: begin
               if (fall) begin
                  nxt_l.sda_oe = 1'b0;
                  nxt_l.cnt = 4'h0;
                  nxt_l.first = 1'b1;
                  if (l_ff.rd) begin
                     // Hold the clock low until the user side has handed over a byte.
                     nxt_l.scl_oe = 1'b1;
                     nxt_l.tx_req = ~l_ff.tx_req;
                     nxt_l.st = tmi_pkg::TS_TXW;
                  end else begin
                     nxt_l.st = tmi_pkg::TS_RX;
                  end
               end
            end
            tmi_pkg::TS_RX: begin
               if (rise) begin
                  nxt_l.sh = {l_ff.sh[6:0], l_ff.sda_s};
                  nxt_l.cnt = l_ff.cnt + 4'h1;
               end
               if (fall && l_ff.cnt == `TMI_DATA_BITS) begin
                  nxt_l.sda_oe = 1'b1;
                  nxt_l.rx_hold = l_ff.sh;
                  nxt_l.rx_tgt = l_ff.tgt;
                  nxt_l.rx_first = l_ff.first;
                  nxt_l.rx_tgl = ~l_ff.rx_tgl;
                  nxt_l.first = 1'b0;
                  nxt_l.st = tmi_pkg::TS_RACK;
               end
            end
            tmi_pkg::TS_RACK: begin
               if (fall) begin
                  nxt_l.sda_oe = 1'b0;
                  nxt_l.cnt = 4'h0;
                  nxt_l.st = tmi_pkg::TS_RX;
               end
            end
            tmi_pkg::TS_TXW: begin
               if (l_ff.ack_s == l_ff.tx_req) begin
                  // The held byte is stable once the acknowledge toggle has crossed.
                  nxt_l.sh = u_ff.tx_hold;
                  nxt_l.sda_oe = ~u_ff.tx_hold[7];
                  nxt_l.scl_oe = 1'b0;
                  nxt_l.cnt = 4'h0;
                  nxt_l.st = tmi_pkg::TS_TX;
               end
            end
            tmi_pkg::TS_TX: begin
               if (fall) begin
                  nxt_l.cnt = l_ff.cnt + 4'h1;
                  if (l_ff.cnt == `TMI_DATA_BITS - 4'h1) begin
                     nxt_l.sda_oe = 1'b0;
                     nxt_l.st = tmi_pkg::TS_TACK;
                  end else begin
                     nxt_l.sh = {l_ff.sh[6:0], 1'b1};
                     nxt_l.sda_oe = ~l_ff.sh[6];
                  end
               end
            end
            tmi_pkg::TS_TACK: begin
               if (rise) begin
                  nxt_l.hack = ~l_ff.sda_s;
               end
               if (fall) begin
                  if (l_ff.hack) begin
                     nxt_l.scl_oe = 1'b1;
                     nxt_l.tx_req = ~l_ff.tx_req;
                     nxt_l.st = tmi_pkg::TS_TXW;
                  end else begin
                     nxt_l.st = tmi_pkg::TS_IDLE;
                  end
               end
            end
            default: begin
               nxt_l.sda_oe = 1'b0;
               nxt_l.scl_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         l_ff <= '{st: tmi_pkg::TS_IDLE, scl_m: 1'b1, scl_s: 1'b1, scl_q: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_q: 1'b1, default: '0};
      end else begin
         l_ff <= nxt_l;
      end
   end

   // User side: toggles carry events in, the held bytes travel beside them.
   always_comb begin
      nxt_u = u_ff;
      nxt_u.rx_m = l_ff.rx_tgl;
      nxt_u.rx_s = u_ff.rx_m;
      nxt_u.rx_q = u_ff.rx_s;
      nxt_u.req_m = l_ff.tx_req;
      nxt_u.req_s = u_ff.req_m;
      nxt_u.busy_m = l_ff.busy;
      nxt_u.busy_s = u_ff.busy_m;
      nxt_u.rx_valid = 1'b0;
      nxt_u.tx_taken = 1'b0;
      if (u_ff.rx_s != u_ff.rx_q) begin
         nxt_u.rx_valid = 1'b1;
         nxt_u.rx_data = l_ff.rx_hold;
         nxt_u.rx_target = l_ff.rx_tgt;
         nxt_u.rx_first = l_ff.rx_first;
      end
      if (u_ff.req_s != u_ff.ack_tgl) begin
         nxt_u.tx_hold = l_ff.tgt ? tx_byte_nav : tx_byte_touch;
         nxt_u.tx_target = l_ff.tgt;
         nxt_u.tx_taken = 1'b1;
         nxt_u.ack_tgl = u_ff.req_s;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         u_ff <= '0;
      end else begin
         u_ff <= nxt_u;
      end
   end

   // Open drain towards the bus; only the enables move.
   assign bus.dev_scl_o  = 1'b0;
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_scl_oe = l_ff.scl_oe;
   assign bus.dev_sda_oe = l_ff.sda_oe;
   assign tx_taken  = u_ff.tx_taken;
   assign tx_target = u_ff.tx_target;
   assign rx_valid  = u_ff.rx_valid;
   assign rx_data   = u_ff.rx_data;
   assign rx_target = u_ff.rx_target;
   assign rx_first  = u_ff.rx_first;
   assign bus_busy  = u_ff.busy_s;
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Bench joining the host end and the target end over one two-wire bus.
// Assumes both design ends, the interface and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "tmi_cfg.svh"
module tb_top;
   logic       clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic       cmd_valid = 1'b0, cmd_ack = 1'b0, addr_strap = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic [7:0] cmd_data = 8'h00, tx_byte_touch = 8'hc3, tx_byte_nav = 8'h5a;
   logic       cmd_ready, rsp_valid, rsp_nack, tx_taken, tx_target;
   logic       rx_valid, rx_target, rx_first, bus_busy, rxt_seen, rxf_seen, txt_seen;
   logic [7:0] rsp_data, rx_data, rx_seen;
   int         miscompares = 0, tests_run = 0, rx_count = 0;
   tmi_bus_if tmi_bus_if_i ();
   tmi_host tmi_host_i (.clock(clock), .rst_n(rst_n), .bus(tmi_bus_if_i.host),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   tmi_target tmi_target_i (.clock(clock), .rst_n(rst_n), .link_clk(link_clk),
      .bus(tmi_bus_if_i.dev), .addr_strap(addr_strap), .tx_byte_touch(tx_byte_touch),
      .tx_byte_nav(tx_byte_nav), .tx_taken(tx_taken), .tx_target(tx_target),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_target(rx_target), .rx_first(rx_first),
      .bus_busy(bus_busy));
   tmi_bus_asserts tmi_bus_asserts_i (.link_clk(link_clk), .rst_n(rst_n),
      .host_scl_o(tmi_bus_if_i.host_scl_o), .host_sda_o(tmi_bus_if_i.host_sda_o),
      .dev_scl_o(tmi_bus_if_i.dev_scl_o), .dev_sda_o(tmi_bus_if_i.dev_sda_o),
      .dev_scl_oe(tmi_bus_if_i.dev_scl_oe), .dev_sda_oe(tmi_bus_if_i.dev_sda_oe),
      .scl(tmi_bus_if_i.scl), .sda(tmi_bus_if_i.sda));
   // Two unrelated clocks; the link clock starts off phase so edges never meet.
   initial forever #20 clock = ~clock;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   // User-side pulses are taken mid-cycle; each sent byte moves that target's next byte on.
   always @(negedge clock) begin
      if (rx_valid === 1'b1) begin
         {rx_seen, rxt_seen, rxf_seen} <= {rx_data, rx_target, rx_first};
         rx_count <= rx_count + 1;
      end
      if (tx_taken === 1'b1) begin
         txt_seen <= tx_target;
         if (tx_target) tx_byte_nav <= tx_byte_nav + 8'h11;
         else tx_byte_touch <= tx_byte_touch + 8'h11;
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One command held until taken; framing then waits for ready, a byte for its answer pulse.
   task automatic xfer(input logic [1:0] c, input logic [7:0] d, input logic a);
      int n;
      for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++) @(negedge clock);
      check("ready", {7'h0, n < 4000}, 8'h01);
      {cmd_valid, cmd, cmd_data, cmd_ack} = {1'b1, c, d, a};
      @(negedge clock);
      cmd_valid = 1'b0;
      @(negedge clock);
      for (n = 0; n < 4000 && (c[1] ? rsp_valid : cmd_ready) !== 1'b1; n++) @(negedge clock);
      check("done", {7'h0, n < 4000}, 8'h01);
   endtask
   task automatic t_write_nav;
      xfer(tmi_pkg::CMD_START, 8'h00, 1'b0);
      check("busy", {7'h0, bus_busy}, 8'h01);
      xfer(tmi_pkg::CMD_WRITE, {`TMI_ADDR_NAV, 1'b0}, 1'b0);
      check("addr_nack", {7'h0, rsp_nack}, 8'h00);
      xfer(tmi_pkg::CMD_WRITE, 8'ha5, 1'b0);
      check("wr_nack", {7'h0, rsp_nack}, 8'h00);
      check("rx_data", rx_seen, 8'ha5);
      check("rx_flags", {6'h0, rxt_seen, rxf_seen}, 8'h03);
      xfer(tmi_pkg::CMD_WRITE, 8'h3c, 1'b0);
      check("rx_data", rx_seen, 8'h3c);
      check("rx_flags", {6'h0, rxt_seen, rxf_seen}, 8'h02);
      xfer(tmi_pkg::CMD_STOP, 8'h00, 1'b0);
      repeat (8) @(negedge clock);
      check("idle", {7'h0, bus_busy}, 8'h00);
   endtask
   // Two reads back to back from the touch target; the second ends with a host refusal.
   task automatic t_read_touch;
      xfer(tmi_pkg::CMD_START, 8'h00, 1'b0);
      xfer(tmi_pkg::CMD_WRITE, {`TMI_ADDR_TOUCH_LO, 1'b1}, 1'b0);
      check("addr_nack", {7'h0, rsp_nack}, 8'h00);
      xfer(tmi_pkg::CMD_READ, 8'h00, 1'b1);
      check("rd_data", rsp_data, 8'hc3);
      check("tx_tgt", {7'h0, txt_seen}, 8'h00);
      xfer(tmi_pkg::CMD_READ, 8'h00, 1'b0);
      check("rd_data", rsp_data, 8'hd4);
      xfer(tmi_pkg::CMD_STOP, 8'h00, 1'b0);
   endtask
   // With the strap set the lower address is foreign; a repeated start reaches the upper one.
   task automatic t_strap;
      int n0;
      addr_strap = 1'b1;
      repeat (6) @(negedge clock);
      n0 = rx_count;
      xfer(tmi_pkg::CMD_START, 8'h00, 1'b0);
      xfer(tmi_pkg::CMD_WRITE, {`TMI_ADDR_TOUCH_LO, 1'b0}, 1'b0);
      check("addr_nack", {7'h0, rsp_nack}, 8'h01);
      xfer(tmi_pkg::CMD_WRITE, 8'h77, 1'b0);
      check("wr_nack", {7'h0, rsp_nack}, 8'h01);
      xfer(tmi_pkg::CMD_START, 8'h00, 1'b0);
      xfer(tmi_pkg::CMD_WRITE, {`TMI_ADDR_TOUCH_HI, 1'b0}, 1'b0);
      check("addr_nack", {7'h0, rsp_nack}, 8'h00);
      xfer(tmi_pkg::CMD_WRITE, 8'h69, 1'b0);
      check("rx_data", rx_seen, 8'h69);
      check("rx_flags", {6'h0, rxt_seen, rxf_seen}, 8'h01);
      check("rx_count", 8'(rx_count - n0), 8'h01);
      xfer(tmi_pkg::CMD_STOP, 8'h00, 1'b0);
      addr_strap = 1'b0;
   endtask
   // A foreign address is refused, then a repeated start reads the key target.
   task automatic t_foreign_nav;
      xfer(tmi_pkg::CMD_START, 8'h00, 1'b0);
      xfer(tmi_pkg::CMD_WRITE, {7'h33, 1'b0}, 1'b0);
      check("addr_nack", {7'h0, rsp_nack}, 8'h01);
      xfer(tmi_pkg::CMD_START, 8'h00, 1'b0);
      xfer(tmi_pkg::CMD_WRITE, {`TMI_ADDR_NAV, 1'b1}, 1'b0);
      check("addr_nack", {7'h0, rsp_nack}, 8'h00);
      xfer(tmi_pkg::CMD_READ, 8'h00, 1'b0);
      check("rd_data", rsp_data, 8'h5a);
      check("tx_tgt", {7'h0, txt_seen}, 8'h01);
      xfer(tmi_pkg::CMD_STOP, 8'h00, 1'b0);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Main sequence after six cycles of reset.
   initial begin
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      t_write_nav();
      t_read_touch();
      t_strap();
      t_foreign_nav();
      give_verdict();
   end
   // Watchdog: about four times the expected run.
   initial begin
      #1_500_000;
      miscompares++;
      give_verdict();
   end
endmodule
`default_nettype wire

// file: verif/tmi_bus_asserts.sv
// Checker for the two-wire bus that joins the host end and the target end.
// Assumes the drivers and the wired lines are handed in by name, sampled on link_clk.
`timescale 1ns/1ps
`default_nettype none
`include "tmi_cfg.svh"
module tmi_bus_asserts (
   input wire logic link_clk,
   input wire logic rst_n,
   input wire logic host_scl_o,
   input wire logic host_sda_o,
   input wire logic dev_scl_o,
   input wire logic dev_sda_o,
   input wire logic dev_scl_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_ff, sda_ff, first_ff, foreign_ff, own_wr_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic       rise, start, stop;
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!rst_n);
   // START and STOP are the only data moves allowed while the clock line is high.
   assign rise  = scl & ~scl_ff;
   assign start = scl & scl_ff & sda_ff & ~sda;
   assign stop  = scl & scl_ff & ~sda_ff & sda;
   // Bit and frame count, restarted by every START so a repeated start is followed too.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_ff, sda_ff, first_ff, foreign_ff, own_wr_ff} <= 5'h18;
         cnt_ff   <= 4'h0;
         shift_ff <= 8'h00;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda;
         if (start) begin
            {first_ff, foreign_ff, own_wr_ff} <= 3'h4;
            cnt_ff <= 4'h0;
         end else if (rise) begin
            shift_ff <= {shift_ff[6:0], sda};
            cnt_ff   <= (cnt_ff == 4'h9) ? 4'h1 : cnt_ff + 4'h1;
            if (first_ff && cnt_ff == 4'h7)
               foreign_ff <= !(shift_ff[6:0] inside
                  {`TMI_ADDR_TOUCH_LO, `TMI_ADDR_TOUCH_HI, `TMI_ADDR_NAV});
            if (first_ff && cnt_ff == 4'h8) begin
               first_ff  <= 1'b0;
               own_wr_ff <= (shift_ff == {`TMI_ADDR_NAV, 1'b0});
            end
         end
      end
   end
   // The ninth rise of the address frame, and the same rise when the key target is called.
   sequence ninth_s;
      rise && first_ff && cnt_ff == 4'h8;
   endsequence
   sequence nav_ninth_s;
      ninth_s ##0 shift_ff[7:1] == `TMI_ADDR_NAV;
   endsequence
   host_odrain_a: assert property (!host_scl_o && !host_sda_o)
      else $error("host drives a line high");
   dev_odrain_a: assert property (!dev_scl_o && !dev_sda_o && !(dev_sda_oe && sda)
      && !(dev_scl_oe && scl))
      else $error("target drives a line high");
   dev_sda_steady_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("target moved data while clock high");
   stretch_slot_a: assert property ($rose(dev_scl_oe) |-> !scl && cnt_ff == 4'h9)
      else $error("clock stretch outside a frame boundary");
   stretch_bound_a: assert property ($rose(dev_scl_oe) |-> ##[1:100] !dev_scl_oe)
      else $error("clock stretch too long");
   addr_ack_a: assert property (nav_ninth_s |-> dev_sda_oe)
      else $error("own address not acknowledged");
   ack_slot_a: assert property (rise && first_ff && dev_sda_oe |-> cnt_ff == 4'h8)
      else $error("target pulled data outside the ninth cycle");
   foreign_quiet_a: assert property (foreign_ff |-> !dev_sda_oe)
      else $error("target answered a foreign address");
   write_ack_a: assert property (rise && own_wr_ff && cnt_ff == 4'h8 |-> dev_sda_oe)
      else $error("written byte not acknowledged");
   stop_release_a: assert property (stop |-> !dev_sda_oe [*8])
      else $error("target holds data after stop");
endmodule
`default_nettype wire
